// ---- clock_source_pkg.sv ----
package clock_source_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_OSC_MODE_SEL  = 8'h00;
   localparam logic [7:0] ADDR_CPU_CLK_CTRL  = 8'h04;
   localparam logic [7:0] ADDR_INT_OSC_MODE  = 8'h08;
   localparam logic [7:0] ADDR_MAIN_OSC_CTRL = 8'h0C;
   localparam logic [7:0] ADDR_MAIN_CLK_SEL  = 8'h10;
   localparam logic [7:0] ADDR_CLK_STATUS    = 8'h14;

   // ----------------------------------------------------------------
   // reset values and writable masks
   // ----------------------------------------------------------------
   localparam logic [7:0] OSC_MODE_RST       = 8'h00;
   localparam logic [7:0] CPU_CTRL_RST       = 8'h01;
   localparam logic [7:0] INT_OSC_RST        = 8'h00;
   localparam logic [7:0] MAIN_OSC_RST       = 8'h80;
   localparam logic [7:0] MAIN_SEL_RST       = 8'h00;
   localparam logic [7:0] OSC_MODE_WMASK     = 8'hF1;
   localparam logic [7:0] CPU_CTRL_WMASK     = 8'h57;
   localparam logic [7:0] INT_OSC_WMASK      = 8'h07;
   localparam logic [7:0] MAIN_OSC_WMASK     = 8'h80;
   localparam logic [7:0] MAIN_SEL_WMASK     = 8'h01;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int OM_EXT_MAIN   = 7;
   localparam int OM_MAIN_MODE  = 6;
   localparam int OM_EXT_SUB    = 5;
   localparam int OM_SUB_MODE   = 4;
   localparam int OM_AMP_HIGH   = 0;
   localparam int CC_SUB_START  = 6;
   localparam int CC_ON_SUB     = 5;
   localparam int CC_SEL_SUB    = 4;
   localparam int CC_DIV_MSB    = 2;
   localparam int IO_SLOW_STOP  = 0;
   localparam int IO_FAST_STOP  = 1;
   localparam int IO_EXT_M_DIS  = 2;
   localparam int MO_MAIN_STOP  = 7;
   localparam int MS_HIGH_SPEED = 0;
   localparam int MS_STATUS     = 1;

   // ----------------------------------------------------------------
   // clock sources, dividers, mux inputs
   // ----------------------------------------------------------------
   localparam int NUM_SRC       = 6;
   localparam int SRC_FAST      = 0;
   localparam int SRC_SLOW      = 1;
   localparam int SRC_MAIN_RES  = 2;
   localparam int SRC_EXT_MAIN  = 3;
   localparam int SRC_SUB_RES   = 4;
   localparam int SRC_EXT_SUB   = 5;
   localparam int SYNC_STAGES   = 3;
   localparam int MAIN_DIV_BITS = 4;
   localparam int CPU_MUX_N     = 6;
   localparam logic [2:0] CPU_SEL_SUB = 3'h5;
   localparam logic [2:0] CPU_DIV_MAX = 3'h4;
   localparam int SLOW_CNT_BITS = 9;
   localparam int SLOW_TAP_128  = 6;
   localparam int SLOW_TAP_512  = 8;
   localparam int TMR_MUX_N     = 4;

   // ----------------------------------------------------------------
   // oscillator enables driven to the analog cells and input gates
   // ----------------------------------------------------------------
   typedef struct packed {
      logic fastOsc;
      logic slowOsc;
      logic mainOsc;
      logic extMain;
      logic subOsc;
      logic extSub;
   } osc_enable_s;

endpackage : clock_source_pkg

// ---- clock_glitch_mux.sv ----
`timescale 1ns/1ps

module clock_glitch_mux #(
   parameter int N       = 2,
   parameter int RST_SEL = 0,
   parameter int SW      = (N > 2) ? $clog2(N) : 1
) (
   input  wire logic          clk,
   input  wire logic          reset,
   input  wire logic [N-1:0]  srcLvl,
   input  wire logic [SW-1:0] sel,
   output logic               clkOut,
   output logic [SW-1:0]      curSel
);

   if (N < 2 || RST_SEL >= N) begin : gBadParam
      $error("clock_glitch_mux: bad N or RST_SEL");
   end

   logic [SW-1:0] curQ;
   logic [SW-1:0] curD;
   logic          parkQ;
   logic          parkD;
   logic          outQ;
   logic          outD;

   // ----------------------------------------------------------------
   // switch only across low phases: park low, then join new source low
   // ----------------------------------------------------------------
   wire switchReq = (sel != curQ);
   wire newLow    = !srcLvl[sel];

   always_comb begin
      curD  = curQ;
      parkD = parkQ;
      if (parkQ) begin
         if (newLow) begin
            curD  = sel;
            parkD = 1'b0;
         end
      end else if (switchReq && !outQ) begin
         parkD = 1'b1;
      end
      outD = parkD ? 1'b0 : srcLvl[curD];
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         curQ  <= SW'(RST_SEL);
         parkQ <= 1'b0;
         outQ  <= 1'b0;
      end else begin
         curQ  <= curD;
         parkQ <= parkD;
         outQ  <= outD;
      end
   end

   assign clkOut = outQ;
   assign curSel = curQ;

endmodule : clock_glitch_mux

// ---- clock_source_control.sv ----
`timescale 1ns/1ps

// How it works
// - processor starts on internal fast oscillator
// - slow oscillator runs from reset release
// - slow stop only when option allows it
// - slow clock never reaches processor
// - slow clock feeds watchdog and timer H1
// - main clock: high-speed or fast oscillator
// - main crystal stops on STOP or software
// - fast oscillator stops on STOP or software
// - external main input blocked by STOP/software
// - subsystem crystal stoppable by software
// - external sub input blockable by software
// - mode register resets 00H, pins ports
// - cpu control resets 01H, main/2
module clock_source_control
   import clock_source_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        stopInstr,
   input  wire logic        slowStopOption,
   input  wire logic        fastOscClkIn,
   input  wire logic        slowOscClkIn,
   input  wire logic        mainResonatorPinA,
   input  wire logic        extMainClockIn,
   input  wire logic        subResonatorPinA,
   input  wire logic        extSubClockIn,
   input  wire logic [1:0]  timerH1ClkSel,
   output osc_enable_s      oscEnable,
   output logic [3:0]       oscPortMode,
   output logic             cpuClk,
   output logic             periphClk,
   output logic             watchdogClk,
   output logic             timerH1Clk,
   output logic             cpuOnSub
);

   // ----------------------------------------------------------------
   // register bank
   // ----------------------------------------------------------------
   logic [7:0] oscModeQ;
   logic [7:0] cpuCtrlQ;
   logic [7:0] intOscQ;
   logic [7:0] mainOscQ;
   logic [7:0] mainSelQ;
   logic       slowStopAllowQ;

   // ----------------------------------------------------------------
   // bus slave state
   // ----------------------------------------------------------------
   logic [7:0]  addrQ;
   logic        wrPhaseQ;
   logic        rdPhaseQ;
   logic        rdValidQ;
   logic [31:0] rdDataQ;

   wire accept   = hsel && htrans[1] && hready;
   wire doWrite  = wrPhaseQ;
   wire selOsc   = (addrQ == ADDR_OSC_MODE_SEL);
   wire selCpu   = (addrQ == ADDR_CPU_CLK_CTRL);
   wire selInt   = (addrQ == ADDR_INT_OSC_MODE);
   wire selMOsc  = (addrQ == ADDR_MAIN_OSC_CTRL);
   wire selMSel  = (addrQ == ADDR_MAIN_CLK_SEL);
   wire selStat  = (addrQ == ADDR_CLK_STATUS);

   function automatic logic [7:0] mergeFn(input logic [7:0] oldV,
                                          input logic [7:0] newV,
                                          input logic [7:0] mask);
      mergeFn = (oldV & ~mask) | (newV & mask);
   endfunction : mergeFn

   // ----------------------------------------------------------------
   // synchronised source levels
   // ----------------------------------------------------------------
   logic [SYNC_STAGES-1:0] syncQ [NUM_SRC];
   logic [NUM_SRC-1:0]     rawIn;
   logic [NUM_SRC-1:0]     lvlQ;
   logic [NUM_SRC-1:0]     gatedLvl;

   assign rawIn[SRC_FAST]     = fastOscClkIn;
   assign rawIn[SRC_SLOW]     = slowOscClkIn;
   assign rawIn[SRC_MAIN_RES] = mainResonatorPinA;
   assign rawIn[SRC_EXT_MAIN] = extMainClockIn;
   assign rawIn[SRC_SUB_RES]  = subResonatorPinA;
   assign rawIn[SRC_EXT_SUB]  = extSubClockIn;

   always_ff @(posedge clk) begin
      for (int i = 0; i < NUM_SRC; i++) begin
         syncQ[i] <= {syncQ[i][SYNC_STAGES-2:0], rawIn[i]};
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         lvlQ <= '0;
      end else begin
         for (int i = 0; i < NUM_SRC; i++) begin
            if (syncQ[i][1] == syncQ[i][2]) begin
               lvlQ[i] <= syncQ[i][2];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // oscillator enables and pin modes
   // ----------------------------------------------------------------
   wire mainMode   = oscModeQ[OM_MAIN_MODE];
   wire extMainSel = oscModeQ[OM_EXT_MAIN];
   wire subMode    = oscModeQ[OM_SUB_MODE];
   wire extSubSel  = oscModeQ[OM_EXT_SUB];
   wire mainStop   = mainOscQ[MO_MAIN_STOP];

   assign oscEnable.fastOsc = !stopInstr && !intOscQ[IO_FAST_STOP];
   assign oscEnable.slowOsc = !(intOscQ[IO_SLOW_STOP] && slowStopAllowQ);
   assign oscEnable.mainOsc = mainMode && !extMainSel && !mainStop && !stopInstr;
   assign oscEnable.extMain = mainMode && extMainSel && !mainStop && !stopInstr
                              && !intOscQ[IO_EXT_M_DIS];
   assign oscEnable.subOsc  = (subMode && !extSubSel) || cpuCtrlQ[CC_SUB_START];
   assign oscEnable.extSub  = subMode && extSubSel;

   // pins stay general ports until a mode or the sub start bit is set
   assign oscPortMode[0] = !(mainMode && !extMainSel);
   assign oscPortMode[1] = !mainMode;
   assign oscPortMode[2] = !(subMode && !extSubSel) && !cpuCtrlQ[CC_SUB_START];
   assign oscPortMode[3] = !subMode && !cpuCtrlQ[CC_SUB_START];

   assign gatedLvl[SRC_FAST]     = lvlQ[SRC_FAST] && oscEnable.fastOsc;
   assign gatedLvl[SRC_SLOW]     = lvlQ[SRC_SLOW] && oscEnable.slowOsc;
   assign gatedLvl[SRC_MAIN_RES] = lvlQ[SRC_MAIN_RES] && oscEnable.mainOsc;
   assign gatedLvl[SRC_EXT_MAIN] = lvlQ[SRC_EXT_MAIN] && oscEnable.extMain;
   assign gatedLvl[SRC_SUB_RES]  = lvlQ[SRC_SUB_RES] && oscEnable.subOsc;
   assign gatedLvl[SRC_EXT_SUB]  = lvlQ[SRC_EXT_SUB] && oscEnable.extSub;

   wire highSpeedLvl = gatedLvl[SRC_MAIN_RES] || gatedLvl[SRC_EXT_MAIN];
   wire subLvl       = gatedLvl[SRC_SUB_RES] || gatedLvl[SRC_EXT_SUB];

   // ----------------------------------------------------------------
   // main system clock select
   // ----------------------------------------------------------------
   logic       mainSysClk;
   logic [0:0] mainCur;

   clock_glitch_mux #(
      .N       (2),
      .RST_SEL (0)
   ) uMainMux (
      .clk    (clk),
      .reset  (reset),
      .srcLvl ({highSpeedLvl, gatedLvl[SRC_FAST]}),
      .sel    (mainSelQ[MS_HIGH_SPEED]),
      .clkOut (mainSysClk),
      .curSel (mainCur)
   );

   assign periphClk = mainSysClk;

   // ----------------------------------------------------------------
   // dividers
   // ----------------------------------------------------------------
   logic                     mainPrevQ;
   logic [MAIN_DIV_BITS-1:0] mainDivQ;
   logic                     subPrevQ;
   logic                     subDivQ;
   logic                     slowPrevQ;
   logic [SLOW_CNT_BITS-1:0] slowCntQ;

   always_ff @(posedge clk) begin
      if (reset) begin
         mainPrevQ <= 1'b0;
         mainDivQ  <= '0;
         subPrevQ  <= 1'b0;
         subDivQ   <= 1'b0;
         slowPrevQ <= 1'b0;
         slowCntQ  <= '0;
      end else begin
         mainPrevQ <= mainSysClk;
         subPrevQ  <= subLvl;
         slowPrevQ <= gatedLvl[SRC_SLOW];
         if (mainSysClk && !mainPrevQ) begin
            mainDivQ <= mainDivQ + 1'b1;
         end
         if (subLvl && !subPrevQ) begin
            subDivQ <= !subDivQ;
         end
         if (gatedLvl[SRC_SLOW] && !slowPrevQ) begin
            slowCntQ <= slowCntQ + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // processor clock select, slow clock excluded from inputs
   // ----------------------------------------------------------------
   logic [2:0] cpuSel;
   logic [2:0] cpuCur;

   assign cpuSel = cpuCtrlQ[CC_SEL_SUB] ? CPU_SEL_SUB :
                   ((cpuCtrlQ[CC_DIV_MSB:0] > CPU_DIV_MAX) ? CPU_DIV_MAX : cpuCtrlQ[CC_DIV_MSB:0]);

   clock_glitch_mux #(
      .N       (CPU_MUX_N),
      .RST_SEL (1)
   ) uCpuMux (
      .clk    (clk),
      .reset  (reset),
      .srcLvl ({subDivQ, mainDivQ, mainSysClk}),
      .sel    (cpuSel),
      .clkOut (cpuClk),
      .curSel (cpuCur)
   );

   assign cpuOnSub = (cpuCur == CPU_SEL_SUB);

   // ----------------------------------------------------------------
   // slow clock consumers
   // ----------------------------------------------------------------
   logic [1:0] tmrCur;

   clock_glitch_mux #(
      .N       (TMR_MUX_N),
      .RST_SEL (0)
   ) uTmrMux (
      .clk    (clk),
      .reset  (reset),
      .srcLvl ({1'b0, slowCntQ[SLOW_TAP_512], slowCntQ[SLOW_TAP_128], gatedLvl[SRC_SLOW]}),
      .sel    (timerH1ClkSel),
      .clkOut (timerH1Clk),
      .curSel (tmrCur)
   );

   logic wdtQ;

   always_ff @(posedge clk) begin
      if (reset) begin
         wdtQ <= 1'b0;
      end else begin
         wdtQ <= gatedLvl[SRC_SLOW];
      end
   end

   assign watchdogClk = wdtQ;

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   wire [7:0] wrByte   = hwdata[7:0];
   wire [7:0] intOscWr = slowStopAllowQ ? wrByte : {wrByte[7:1], intOscQ[IO_SLOW_STOP]};

   always_ff @(posedge clk) begin
      if (reset) begin
         oscModeQ       <= OSC_MODE_RST;
         cpuCtrlQ       <= CPU_CTRL_RST;
         intOscQ        <= INT_OSC_RST;
         mainOscQ       <= MAIN_OSC_RST;
         mainSelQ       <= MAIN_SEL_RST;
         slowStopAllowQ <= slowStopOption;
      end else if (doWrite) begin
         if (selOsc) begin
            oscModeQ <= mergeFn(oscModeQ, wrByte, OSC_MODE_WMASK);
         end
         if (selCpu) begin
            cpuCtrlQ <= mergeFn(cpuCtrlQ, wrByte, CPU_CTRL_WMASK);
         end
         if (selInt) begin
            intOscQ <= mergeFn(intOscQ, intOscWr, INT_OSC_WMASK);
         end
         if (selMOsc) begin
            mainOscQ <= mergeFn(mainOscQ, wrByte, MAIN_OSC_WMASK);
         end
         if (selMSel) begin
            mainSelQ <= mergeFn(mainSelQ, wrByte, MAIN_SEL_WMASK);
         end
      end
   end

   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------
   logic [7:0] cpuCtrlRd;
   logic [7:0] mainSelRd;
   logic [7:0] statusRd;
   logic [7:0] readByte;

   assign cpuCtrlRd = {cpuCtrlQ[7:CC_ON_SUB+1], cpuOnSub, cpuCtrlQ[CC_ON_SUB-1:0]};
   assign mainSelRd = {mainSelQ[7:MS_STATUS+1], mainCur[0], mainSelQ[MS_STATUS-1:0]};
   assign statusRd  = {1'b0, slowStopAllowQ, oscEnable};
   assign readByte  = selOsc  ? oscModeQ  :
                      selCpu  ? cpuCtrlRd :
                      selInt  ? intOscQ   :
                      selMOsc ? mainOscQ  :
                      selMSel ? mainSelRd :
                      selStat ? statusRd  : 8'h00;

   // ----------------------------------------------------------------
   // bus phases: writes without wait, reads with one wait state
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         addrQ    <= '0;
         wrPhaseQ <= 1'b0;
         rdPhaseQ <= 1'b0;
         rdValidQ <= 1'b0;
         rdDataQ  <= '0;
      end else begin
         rdValidQ <= rdPhaseQ && !rdValidQ;
         if (rdPhaseQ && !rdValidQ) begin
            rdDataQ <= {24'h000000, readByte};
         end
         if (hreadyout) begin
            wrPhaseQ <= accept && hwrite;
            rdPhaseQ <= accept && !hwrite;
            if (accept) begin
               addrQ <= haddr[7:0];
            end
         end
      end
   end

   assign hreadyout = !(rdPhaseQ && !rdValidQ);
   assign hrdata    = rdDataQ;
   assign hresp     = 1'b0;

endmodule : clock_source_control

// ---- clock_source_control_sva.sv ----
`timescale 1ns/1ps

module clock_source_control_sva
   import clock_source_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        stopInstr,
   input wire logic        slowStopOption,
   input wire osc_enable_s oscEnable,
   input wire logic [3:0]  oscPortMode,
   input wire logic        cpuClk,
   input wire logic        periphClk,
   input wire logic        watchdogClk
);
   // --------------------
   // helper logic
   // --------------------
   logic       optQ;
   logic       wdtPrevQ;
   logic [5:0] quietCnt;
   logic [5:0] wdtIdle;
   wire        taken     = hsel & htrans[1] & hready & hreadyout;
   wire        othersOff = ~(oscEnable.fastOsc | oscEnable.mainOsc | oscEnable.extMain |
                             oscEnable.subOsc | oscEnable.extSub);

   always_ff @(posedge clk) begin
      if (reset) begin
         optQ <= slowStopOption;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || !othersOff) begin
         quietCnt <= 6'h00;
      end else if (quietCnt != 6'h3F) begin
         quietCnt <= quietCnt + 6'h01;
      end
   end

   // cycles since the watchdog clock last moved while the slow source is enabled
   always_ff @(posedge clk) begin
      wdtPrevQ <= watchdogClk;
      if (reset || !oscEnable.slowOsc || watchdogClk != wdtPrevQ) begin
         wdtIdle <= 6'h00;
      end else if (wdtIdle != 6'h3F) begin
         wdtIdle <= wdtIdle + 6'h01;
      end
   end

   // --------------------
   // properties
   // --------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence readTaken;
      taken && !hwrite;
   endsequence
   sequence readAnswer;
      !hreadyout ##1 (hreadyout && hrdata[31:8] == 24'h000000);
   endsequence

   a_reset_defaults: assert property ($fell(reset) |-> oscEnable == 6'h30 && oscPortMode == 4'hF)
      else $error("enables or port mode wrong after reset");
   a_stop_gates: assert property (stopInstr |-> !oscEnable.fastOsc && !oscEnable.mainOsc && !oscEnable.extMain)
      else $error("stop left a main source enabled");
   a_slow_kept: assert property (!optQ |-> oscEnable.slowOsc)
      else $error("slow oscillator stopped without option");
   a_slow_not_cpu: assert property (quietCnt >= 6'h30 |-> $stable(cpuClk))
      else $error("cpu clock moves with only slow source running");
   a_cpu_high: assert property ($rose(cpuClk) |=> cpuClk [*3])
      else $error("short cpu clock high phase");
   a_periph_low: assert property ($fell(periphClk) |=> !periphClk [*3])
      else $error("short peripheral clock low phase");
   a_wdt_runs: assert property (wdtIdle < 6'h28)
      else $error("watchdog clock idle while slow source runs");
   a_read_wait: assert property (readTaken |=> readAnswer)
      else $error("read answer timing or upper data wrong");
   a_write_nowait: assert property (taken && hwrite |=> hreadyout)
      else $error("write data phase stalled");
endmodule : clock_source_control_sva

bind clock_source_control clock_source_control_sva u_sva (
   .clk(clk), .reset(reset), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .stopInstr(stopInstr), .slowStopOption(slowStopOption),
   .oscEnable(oscEnable), .oscPortMode(oscPortMode), .cpuClk(cpuClk), .periphClk(periphClk),
   .watchdogClk(watchdogClk)
);

// ---- clock_osc_model.sv ----
`timescale 1ns/1ps

module clock_osc_model
   import clock_source_pkg::*;
#(
   parameter real SCALE = 1.0
) (
   input  wire osc_enable_s oscEnable,
   output logic [5:0]       srcLvl
);
   // --------------------
   // free-running sources; a stopped one ends its phase, then rests low
   // --------------------
   real halfNs [5:0] = '{60.3, 200.7, 70.1, 80.9, 300.3, 340.7};

   initial srcLvl = 6'h00;
   for (genvar i = 0; i < 6; i++) begin : g_src
      always begin
         #(halfNs[i] * SCALE);
         srcLvl[i] = oscEnable[i] ? ~srcLvl[i] : 1'b0;
      end
   end
endmodule : clock_osc_model

// ---- tb_clock_source_control.sv ----
`timescale 1ns/1ps

module tb_clock_source_control
   import clock_source_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        stopInstr = 1'b0;
   logic        slowStopOption = 1'b0;
   logic [1:0]  timerH1ClkSel = 2'h0;
   logic        hreadyout, hresp, cpuClk, periphClk, watchdogClk, timerH1Clk, cpuOnSub;
   logic [31:0] hrdata, rd;
   logic [5:0]  srcLvl;
   logic [3:0]  oscPortMode;
   osc_enable_s oscEnable;
   int          failures, n_tests, cpuRise, tmrEdge, wdtEdge;

   clock_source_control u_dut (
      .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .stopInstr(stopInstr), .slowStopOption(slowStopOption),
      .fastOscClkIn(srcLvl[5]), .slowOscClkIn(srcLvl[4]), .mainResonatorPinA(srcLvl[3]),
      .extMainClockIn(srcLvl[2]), .subResonatorPinA(srcLvl[1]), .extSubClockIn(srcLvl[0]),
      .timerH1ClkSel(timerH1ClkSel), .oscEnable(oscEnable), .oscPortMode(oscPortMode),
      .cpuClk(cpuClk), .periphClk(periphClk), .watchdogClk(watchdogClk), .timerH1Clk(timerH1Clk),
      .cpuOnSub(cpuOnSub)
   );
   clock_osc_model u_osc (.oscEnable(oscEnable), .srcLvl(srcLvl));

   always #5 clk = ~clk;
   always @(posedge cpuClk) cpuRise++;
   always @(timerH1Clk) tmrEdge++;
   always @(watchdogClk) wdtEdge++;

   // --------------------
   // helpers
   // --------------------
   function automatic logic [3:0] portExp(input logic [7:0] v);
      logic [1:0] m;
      logic [1:0] s;
      m = v[6] ? (v[7] ? 2'h1 : 2'h0) : 2'h3;
      s = v[4] ? (v[5] ? 2'h1 : 2'h0) : 2'h3;
      return {s, m};
   endfunction : portExp

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask : chk

   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      #1;
   endtask : xfer

   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : ticks

   task automatic runs(input string s, input logic e, ref int c, input int n);
      int c0;
      c0 = c;
      ticks(n);
      chk(s, {31'h0, e}, {31'h0, c != c0});
   endtask : runs

   task automatic doReset(input logic opt);
      @(posedge clk);
      reset <= 1'b1;
      slowStopOption <= opt;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      ticks(1);
   endtask : doReset

   task automatic resetVals();
      logic [7:0] ad [5] = '{ADDR_OSC_MODE_SEL, ADDR_CPU_CLK_CTRL, ADDR_INT_OSC_MODE,
                             ADDR_MAIN_OSC_CTRL, ADDR_MAIN_CLK_SEL};
      logic [7:0] ex [5] = '{8'h00, 8'h01, 8'h00, 8'h80, 8'h00};
      for (int i = 0; i < 5; i++) begin
         xfer(1'b0, ad[i], 32'h0);
         chk("reset value", {24'h0, ex[i]}, rd);
      end
   endtask : resetVals

   task automatic regRandom(input logic opt);
      logic [7:0] v;
      logic [7:0] w;
      for (int i = 0; i < 8; i++) begin
         v = (i == 0) ? 8'hFF : 8'($urandom);
         w = (i == 0) ? 8'hFF : 8'($urandom);
         xfer(1'b1, ADDR_OSC_MODE_SEL, {24'h0, v});
         xfer(1'b0, ADDR_OSC_MODE_SEL, 32'h0);
         chk("osc mode", {24'h0, v & 8'hF1}, rd);
         chk("port mode", {28'h0, portExp(v)}, {28'h0, oscPortMode});
         xfer(1'b1, ADDR_INT_OSC_MODE, {24'h0, w});
         xfer(1'b0, ADDR_INT_OSC_MODE, 32'h0);
         chk("int osc", {29'h0, w[2:1], w[0] & opt}, rd);
         chk("fast en", {31'h0, ~w[1]}, {31'h0, oscEnable.fastOsc});
         chk("slow en", {31'h0, ~(w[0] & opt)}, {31'h0, oscEnable.slowOsc});
      end
      xfer(1'b1, ADDR_INT_OSC_MODE, 32'h0);
      xfer(1'b1, ADDR_OSC_MODE_SEL, 32'h0);
   endtask : regRandom

   task automatic gate(input logic [7:0] m, input logic [7:0] io, input logic [7:0] mo,
                       input logic st, input logic [5:0] e);
      @(posedge clk);
      stopInstr <= st;
      xfer(1'b1, ADDR_OSC_MODE_SEL, {24'h0, m});
      xfer(1'b1, ADDR_INT_OSC_MODE, {24'h0, io});
      xfer(1'b1, ADDR_MAIN_OSC_CTRL, {24'h0, mo});
      chk("enables", {26'h0, e}, {26'h0, oscEnable});
   endtask : gate

   task automatic summarize();
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize

   // --------------------
   // tests
   // --------------------
   initial begin
      repeat (90000) @(posedge clk);
      failures++;
      summarize();
   end

   initial begin
      void'($urandom(32'hD71A));
      doReset(1'b0);
      resetVals();
      xfer(1'b1, 8'h18, 32'hFFFFFFFF);
      xfer(1'b0, 8'h18, 32'h0);
      chk("unmapped", 32'h0, rd);
      chk("hresp", 32'h0, {31'h0, hresp});
      chk("enables", 32'h30, {26'h0, oscEnable});
      chk("port mode", 32'hF, {28'h0, oscPortMode});
      runs("cpu clock", 1'b1, cpuRise, 200);
      runs("watchdog", 1'b1, wdtEdge, 200);
      xfer(1'b1, ADDR_CPU_CLK_CTRL, 32'h04);
      ticks(400);
      cpuRise = 0;
      ticks(2000);
      chk("cpu div16", 32'h1, {31'h0, cpuRise inside {[9:12]}});
      xfer(1'b1, ADDR_CPU_CLK_CTRL, 32'h01);
      xfer(1'b1, ADDR_INT_OSC_MODE, 32'h2);
      ticks(60);
      runs("cpu on slow", 1'b0, cpuRise, 300);
      runs("watchdog alone", 1'b1, wdtEdge, 100);
      xfer(1'b1, ADDR_INT_OSC_MODE, 32'h0);
      @(posedge clk);
      timerH1ClkSel <= 2'h3;
      ticks(60);
      runs("timer off", 1'b0, tmrEdge, 300);
      for (int s = 0; s < 3; s++) begin
         @(posedge clk);
         timerH1ClkSel <= 2'(s);
         runs("timer h1", 1'b1, tmrEdge, (s == 0) ? 200 : (s == 1) ? 6000 : 22000);
      end
      regRandom(1'b0);
      gate(8'hC0, 8'h00, 8'h00, 1'b0, 6'h34);
      gate(8'hC0, 8'h00, 8'h00, 1'b1, 6'h10);
      gate(8'hC0, 8'h04, 8'h00, 1'b0, 6'h30);
      gate(8'hC0, 8'h00, 8'h80, 1'b0, 6'h30);
      gate(8'h40, 8'h00, 8'h00, 1'b1, 6'h10);
      gate(8'h40, 8'h00, 8'h80, 1'b0, 6'h30);
      gate(8'h40, 8'h02, 8'h00, 1'b0, 6'h18);
      gate(8'h40, 8'h00, 8'h00, 1'b0, 6'h38);
      xfer(1'b1, ADDR_MAIN_CLK_SEL, 32'h1);
      ticks(300);
      xfer(1'b0, ADDR_MAIN_CLK_SEL, 32'h0);
      chk("main select", 32'h3, rd);
      runs("cpu on crystal", 1'b1, cpuRise, 200);
      xfer(1'b1, ADDR_MAIN_CLK_SEL, 32'h0);
      ticks(300);
      xfer(1'b0, ADDR_MAIN_CLK_SEL, 32'h0);
      chk("main select", 32'h0, rd);
      gate(8'h30, 8'h00, 8'h80, 1'b0, 6'h31);
      gate(8'h10, 8'h00, 8'h80, 1'b0, 6'h32);
      xfer(1'b1, ADDR_CPU_CLK_CTRL, 32'h51);
      ticks(600);
      xfer(1'b0, ADDR_CPU_CLK_CTRL, 32'h0);
      chk("cpu ctrl on sub", 32'h71, rd);
      chk("on sub", 32'h1, {31'h0, cpuOnSub});
      xfer(1'b1, ADDR_CPU_CLK_CTRL, 32'h01);
      ticks(600);
      chk("on sub", 32'h0, {31'h0, cpuOnSub});
      gate(8'h00, 8'h00, 8'h80, 1'b0, 6'h30);
      xfer(1'b1, ADDR_CPU_CLK_CTRL, 32'h41);
      chk("sub start", 32'h1, {31'h0, oscEnable.subOsc});
      doReset(1'b1);
      resetVals();
      regRandom(1'b1);
      summarize();
   end
endmodule : tb_clock_source_control
